// File: hw/jrp_top.sv
// Purpose : Boundary-scan port with arming, erase, program and verify of a row array
// Assumes : Test clock is a separate domain; power-up reset also resets the port
// Notes   : Array and timed operations live on the system clock
// Functional notes
// - Code 1001 selects the programming register and arms array commands.
// - Arming must come first; it lasts until the logic-reset state.
// - Code 1010 erases the whole array using the programming register path.
// - Code 1011 writes the programming register into the addressed row.
// - Code 1100 copies the addressed row into the programming register.
// - During array commands, pins show the values preloaded by sample/preload.
// - Array is reprogrammed only through the scan port; power-up reset also sets every row to the erased level.
// - Input sampled on rising edge, output driven on falling, idle undriven.
// - Code 0010 samples pins and preloads the boundary output latches.
// - No test-reset pin; power-up reset resets the access state machine.
`timescale 1ns/1ns
module jrp_top
#(
  parameter int ROWS         = jrp_pkg::ROWS_DEF,
  parameter int ROW_W        = jrp_pkg::ROW_W_DEF,
  parameter int PINS         = jrp_pkg::PINS_DEF,
  parameter int ERASE_CYCLES = jrp_pkg::ERASE_CYC_DEF,
  parameter int PROG_CYCLES  = jrp_pkg::PROG_CYC_DEF
) (
  // System clock and power-up reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // Scan port, link clock domain
  input  wire logic              i_tck,
  input  wire logic              i_tms,
  input  wire logic              i_tdi,
  output logic                   o_tdo,
  output logic                   o_tdo_oe,
  // Device pins
  input  wire logic [PINS-1:0]   i_pin_in,
  input  wire logic [PINS-1:0]   i_core_out,
  input  wire logic [PINS-1:0]   i_core_oe,
  output logic      [PINS-1:0]   o_pin_out,
  output logic      [PINS-1:0]   o_pin_oe,
  // Array status
  output logic                   o_array_busy
);
  import jrp_pkg::*;
  localparam int AW   = (ROWS > 1) ? $clog2(ROWS) : 1;
  localparam int SR_W = ROW_W + AW;
  // Link-domain state
  logic                 rst_tck_n;
  jrp_tap_t             tap_reg, tap_next;
  logic [IR_W-1:0]      ir_sh_reg;
  logic [IR_W-1:0]      ir_reg;
  logic                 armed_reg;
  logic                 byp_reg;
  logic [PINS-1:0]      bsr_sh_reg;
  logic [PINS-1:0]      bsr_lat_reg;
  logic [SR_W-1:0]      prog_sh_reg;
  logic                 req_tgl_reg;
  logic [1:0]           op_reg;
  logic                 ack_tck;
  // System-domain state
  jrp_seq_t             seq_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic                 req_ref;
  logic                 req_seen_reg;
  logic                 ack_tgl_reg;
  logic [1:0]           op_ref_reg;
  logic [ROW_W-1:0]     arr_reg [ROWS];
  logic [ROW_W-1:0]     rdata_reg;
  logic                 mode_ref;
  logic                 mode_tck_reg;
  // Power-up reset reaches the link domain with a synchronous release
  jrp_sync #(.RST_VAL(1'b0)) u_rst_sync (.i_clk(i_tck), .i_rst_n(i_rst_n),
                                         .i_d(1'b1), .o_q(rst_tck_n));
  // Access state machine transitions
  always_comb
  begin
    tap_next = tap_reg;
    unique case (tap_reg)
      TAP_RESET:  tap_next = i_tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = i_tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = i_tms ? TAP_UPD_DR : TAP_PS_DR;
      TAP_PS_DR:  tap_next = i_tms ? TAP_EX2_DR : TAP_PS_DR;
      TAP_EX2_DR: tap_next = i_tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = i_tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = i_tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = i_tms ? TAP_UPD_IR : TAP_PS_IR;
      TAP_PS_IR:  tap_next = i_tms ? TAP_EX2_IR : TAP_PS_IR;
      TAP_EX2_IR: tap_next = i_tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = i_tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  end
  // Instruction decode; at Update-IR the shifted code is the one about to take effect
  wire [IR_W-1:0] ir_eff = (tap_reg == TAP_UPD_IR) ? ir_sh_reg : ir_reg;
  wire sel_prog   = ir_reg inside {IR_ARM, IR_ERASE, IR_PROGRAM, IR_VERIFY};
  wire sel_bsr    = (ir_reg == IR_SAMPLE);
  wire array_cmd  = ir_eff inside {IR_ERASE, IR_PROGRAM, IR_VERIFY};
  wire mode_next  = (armed_reg || (ir_sh_reg == IR_ARM))
                  && (ir_sh_reg inside {IR_ARM, IR_ERASE, IR_PROGRAM, IR_VERIFY});
  wire pending    = req_tgl_reg != ack_tck;
  wire enter_idle = (tap_next == TAP_IDLE) && (tap_reg inside {TAP_UPD_IR, TAP_UPD_DR});
  // Commands run only when armed; one issued before the last has finished is dropped
  wire launch     = enter_idle && array_cmd && armed_reg && !pending;
  wire [1:0] op_code = (ir_eff == IR_ERASE)   ? OP_ERASE   :
                       (ir_eff == IR_PROGRAM) ? OP_PROGRAM : OP_VERIFY;
  wire dr_lsb     = sel_prog ? prog_sh_reg[0] : (sel_bsr ? bsr_sh_reg[0] : byp_reg);
  wire tdo_bit    = (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : dr_lsb;
  wire shifting   = (tap_reg == TAP_SH_IR) || (tap_reg == TAP_SH_DR);
  // State, instruction and arming
  always_ff @(posedge i_tck or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      tap_reg   <= TAP_RESET;
      ir_reg    <= IR_BYPASS;
      ir_sh_reg <= '0;
      armed_reg <= 1'b0;
    end
    else
    begin
      tap_reg <= tap_next;
      if (tap_reg == TAP_CAP_IR)
        ir_sh_reg <= IR_CAPTURE;
      else if (tap_reg == TAP_SH_IR)
        ir_sh_reg <= {i_tdi, ir_sh_reg[IR_W-1:1]};
      if (tap_reg == TAP_RESET)
      begin
        ir_reg    <= IR_BYPASS;
        armed_reg <= 1'b0;
      end
      else if (tap_reg == TAP_UPD_IR)
      begin
        ir_reg <= ir_sh_reg;
        if (ir_sh_reg == IR_ARM)
          armed_reg <= 1'b1;
      end
    end
  end
  // Data registers: bypass, boundary and programming
  always_ff @(posedge i_tck or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      byp_reg     <= 1'b0;
      bsr_sh_reg  <= '0;
      bsr_lat_reg <= '0;
      prog_sh_reg <= '0;
    end
    else
    begin
      if (tap_reg == TAP_CAP_DR)
      begin
        byp_reg <= 1'b0;
        if (sel_bsr)
          bsr_sh_reg <= i_pin_in;
        if ((ir_reg == IR_VERIFY) && armed_reg && !pending)
          prog_sh_reg <= {prog_sh_reg[SR_W-1 -: AW], rdata_reg};
      end
      else if (tap_reg == TAP_SH_DR)
      begin
        byp_reg <= i_tdi;
        if (sel_bsr)
          bsr_sh_reg <= {i_tdi, bsr_sh_reg[PINS-1:1]};
        if (sel_prog)
          prog_sh_reg <= {i_tdi, prog_sh_reg[SR_W-1:1]};
      end
      if ((tap_reg == TAP_UPD_DR) && sel_bsr)
        bsr_lat_reg <= bsr_sh_reg;
    end
  end
  // Request toggle toward the array; register contents are not locked and can still be shifted before the answer
  always_ff @(posedge i_tck or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      req_tgl_reg  <= 1'b0;
      op_reg       <= OP_ERASE;
      mode_tck_reg <= 1'b0;
    end
    else
    begin
      // Set with the instruction itself: the test clock may stop right after Update-IR
      if (tap_reg == TAP_RESET)
        mode_tck_reg <= 1'b0;
      else if (tap_reg == TAP_UPD_IR)
        mode_tck_reg <= mode_next;
      if (launch)
      begin
        req_tgl_reg <= ~req_tgl_reg;
        op_reg      <= op_code;
      end
    end
  end
  // Serial output changes on the falling edge and floats when idle
  always_ff @(negedge i_tck or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else
    begin
      o_tdo    <= shifting ? tdo_bit : 1'b0;
      o_tdo_oe <= shifting;
    end
  end
  // Crossings: request, answer and pin-override mode
  jrp_sync u_req_sync (.i_clk(i_ref_clk), .i_rst_n(i_rst_n),
                       .i_d(req_tgl_reg), .o_q(req_ref));
  jrp_sync u_ack_sync (.i_clk(i_tck), .i_rst_n(rst_tck_n),
                       .i_d(ack_tgl_reg), .o_q(ack_tck));
  jrp_sync u_mode_sync (.i_clk(i_ref_clk), .i_rst_n(i_rst_n),
                        .i_d(mode_tck_reg), .o_q(mode_ref));
  // Sequencer decode; row address sits above the row data in the register
  wire            new_req  = req_ref != req_seen_reg;
  wire [AW-1:0]   row_addr = prog_sh_reg[SR_W-1 -: AW];
  wire [ROW_W-1:0] row_data = prog_sh_reg[ROW_W-1:0];
  wire [CNT_W-1:0] op_len  = (op_ref_reg == OP_ERASE)   ? CNT_W'(ERASE_CYCLES) :
                             (op_ref_reg == OP_PROGRAM) ? CNT_W'(PROG_CYCLES)  :
                                                          CNT_W'(VERIFY_CYCLES);
  wire            op_end   = (seq_reg == SEQ_BUSY) && (cnt_reg == op_len - CNT_W'(1));
  // Timed array operations; the cells change only at the end of the pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seq_reg      <= SEQ_IDLE;
      cnt_reg      <= '0;
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
      op_ref_reg   <= OP_ERASE;
    end
    else
    begin
      unique case (seq_reg)
        SEQ_IDLE:
          if (new_req)
          begin
            req_seen_reg <= req_ref;
            op_ref_reg   <= op_reg;
            cnt_reg      <= '0;
            seq_reg      <= SEQ_BUSY;
          end
        SEQ_BUSY:
          if (op_end)
          begin
            ack_tgl_reg <= ~ack_tgl_reg;
            seq_reg     <= SEQ_IDLE;
          end
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
      endcase
    end
  end
  // Array storage and read-back word
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int r = 0; r < ROWS; r++)
        arr_reg[r] <= {ROW_W{ERASED_BIT}};
      rdata_reg <= '0;
    end
    else if (op_end)
    begin
      if (op_ref_reg == OP_ERASE)
      begin
        for (int r = 0; r < ROWS; r++)
          arr_reg[r] <= {ROW_W{ERASED_BIT}};
      end
      else if (op_ref_reg == OP_PROGRAM)
        arr_reg[row_addr] <= row_data;
      else
        rdata_reg <= arr_reg[row_addr];
    end
  end
  // Pins follow preloaded latches while array commands are in force
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pin_out    <= '0;
      o_pin_oe     <= '0;
      o_array_busy <= 1'b0;
    end
    else
    begin
      o_pin_out    <= mode_ref ? bsr_lat_reg : i_core_out;
      o_pin_oe     <= mode_ref ? {PINS{1'b1}} : i_core_oe;
      o_array_busy <= (seq_reg == SEQ_BUSY);
    end
  end
endmodule : jrp_top

// File: hw/jrp_pkg.sv
// Purpose : Shared constants for the boundary-scan reprogramming command block
// Assumes : 100 MHz system clock, 4-bit instruction register
// Notes   : Array geometry is a parameter default; timing figures kept in their own units
package jrp_pkg;
  // Instruction codes
  localparam logic [3:0] IR_SAMPLE   = 4'h2;
  localparam logic [3:0] IR_ARM      = 4'h9;
  localparam logic [3:0] IR_ERASE    = 4'ha;
  localparam logic [3:0] IR_PROGRAM  = 4'hb;
  localparam logic [3:0] IR_VERIFY   = 4'hc;
  localparam logic [3:0] IR_BYPASS   = 4'hf;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;  // Fixed pattern captured into the IR
  localparam int         IR_W        = 4;

  // Array geometry defaults
  localparam int ROWS_DEF    = 8;
  localparam int ROW_W_DEF   = 16;
  localparam int PINS_DEF    = 8;
  localparam logic ERASED_BIT = 1'b1;         // Level held by an erased cell

  // Operation kinds passed across the clock boundary
  localparam logic [1:0] OP_ERASE   = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_VERIFY  = 2'h2;

  // Timing figures in their own units and the system clock rate
  localparam int CLK_MHZ        = 100;
  localparam int ERASE_TIME_MS  = 100;
  localparam int PROG_TIME_MS   = 10;
  localparam int VERIFY_TIME_US = 10;
  localparam int VERIFY_CYCLES  = VERIFY_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC_DEF  = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYC_DEF   = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W          = 24;

  // Test access state machine, one-hot
  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PS_DR   = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PS_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } jrp_tap_t;

  // Array sequencer, one-hot
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_BUSY = 2'h2
  } jrp_seq_t;
endpackage : jrp_pkg

// File: hw/jrp_sync.sv
// Purpose : Two-stage level synchroniser with asynchronous reset
// Assumes : Input is a level or a toggle held for several destination cycles
// Notes   : The first stage feeds only the second
`timescale 1ns/1ns
module jrp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Level in and out
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_reg;

  // Reset takes a constant only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= RST_VAL;
      o_q      <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule : jrp_sync

// File: bench/jrp_top_monitor.sv
// Purpose : Port checker for the scan reprogramming block
// Assumes : Everything sampled on the reference clock
// Notes   : A busy run must last exactly one of the pulse counts
`timescale 1ns/1ns
module jrp_top_monitor
  import jrp_pkg::*;
#(
  parameter int PINS         = 8,
  parameter int ERASE_CYCLES = 20,
  parameter int PROG_CYCLES  = 10
) (
  // Clocks and reset
  input wire logic            i_ref_clk,
  input wire logic            i_rst_n,
  input wire logic            i_tck,
  // Watched outputs
  input wire logic            o_tdo,
  input wire logic            o_tdo_oe,
  input wire logic [PINS-1:0] o_pin_out,
  input wire logic [PINS-1:0] o_pin_oe,
  input wire logic            o_array_busy
);
  int run_reg;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Busy run length, so a pulse counter off by one shows up
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      run_reg <= 0;
    else
      run_reg <= o_array_busy ? run_reg + 1 : 0;
  sequence s_busy_start;
    $rose(o_array_busy);
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0)
    !i_rst_n |-> !o_array_busy && !o_tdo_oe && o_pin_oe == '0) else $error("active in reset");
  tdo_idle_a: assert property (!o_tdo_oe |-> !o_tdo)
    else $error("serial out not parked");
  tdo_edge_a: assert property ($changed(o_tdo) |-> !i_tck)
    else $error("serial out moved off falling edge");
  oe_edge_a: assert property ($changed(o_tdo_oe) |-> !i_tck)
    else $error("serial enable moved off falling edge");
  busy_len_a: assert property ($fell(o_array_busy) |->
    run_reg inside {ERASE_CYCLES, PROG_CYCLES, VERIFY_CYCLES}) else $error("bad pulse length");
  busy_pins_a: assert property (o_array_busy |-> &o_pin_oe)
    else $error("pins not driven during operation");
  pins_hold_a: assert property (o_array_busy && $past(o_array_busy) |-> $stable(o_pin_out))
    else $error("pins moved during operation");
  busy_quiet_a: assert property (s_busy_start |-> !o_tdo_oe [*2])
    else $error("operation started while shifting");
endmodule : jrp_top_monitor

bind jrp_top jrp_top_monitor #(
  .PINS(PINS), .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)
) u_mon (.i_ref_clk, .i_rst_n, .i_tck, .o_tdo, .o_tdo_oe, .o_pin_out, .o_pin_oe, .o_array_busy);

// File: bench/jrp_ctrl_model.sv
// Purpose : Outside scan controller driving test clock, mode and data lines
// Assumes : Test clock of 80 ns, stopped low between frames
// Notes   : Released data line parks high, as its pull-up would hold it
`timescale 1ns/1ns
module jrp_ctrl_model (
  // Scan lines driven
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  // Serial return line
  input  wire logic i_tdo
);
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // One clock period; lines change only while the clock is low
  task automatic step(input logic ms, input logic di, output logic q);
    o_tms = ms;
    o_tdi = di;
    #40;
    q = i_tdo;
    o_tck = 1'b1;
    #40;
    o_tck = 1'b0;
  endtask : step

  // Five high mode bits reach logic-reset, then park in idle
  task automatic tlr;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tlr

  // Scan from idle, LSB first, back to idle where array commands launch
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    #(17 - $time % 10); // Keep test clock edges clear of reference edges
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : jrp_ctrl_model

// File: bench/tb_jrp_top.sv
// Purpose : Self-checking bench for the scan reprogramming block
// Assumes : Partner model drives the scan port, bench drives the pins
// Notes   : Short pulse counts keep erase and program waits small
`timescale 1ns/1ns
module tb_jrp_top;
  import jrp_pkg::*;
  localparam int         EC   = 20;
  localparam int         PC   = 10;
  localparam logic [7:0] PRE  = 8'h5a;
  logic                  clk, rst_n, tck, tms, tdi, tdo, tdo_oe, busy;
  logic [7:0]            pin_in, core_out, core_oe, pin_out, pin_oe;
  logic [31:0]           d;
  int                    n_mismatch, n_tests;
  wire logic             tdo_w;
  assign tdo_w = tdo_oe ? tdo : 1'b1; // Pull-up holds the released line

  jrp_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_in(pin_in), .i_core_out(core_out),
    .i_core_oe(core_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_array_busy(busy));
  jrp_ctrl_model ctrl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));

  // Reference clock
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Bounded wait for busy to reach a level; a hang ends the run
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    if (busy !== lvl)
    begin
      n_mismatch++;
      final_report;
    end
  endtask : wait_busy

  // The register may not be shifted again until the operation is over
  task automatic op_done;
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 1200);
  endtask : op_done

  // Nothing may launch while disarmed
  task automatic no_op;
    logic seen;
    seen = 1'b0;
    repeat (50)
    begin
      @(negedge clk);
      seen |= busy;
    end
    check(seen, 1'b0);
  endtask : no_op

  task automatic t_unarmed;
    ctrl.scan(1'b1, IR_PROGRAM, 4, d);
    check(d[3:0], IR_CAPTURE);
    no_op;
  endtask : t_unarmed

  task automatic t_preload;
    ctrl.scan(1'b1, IR_SAMPLE, 4, d);
    ctrl.scan(1'b0, PRE, 8, d);
    check(d[7:0], pin_in);
    check({pin_oe, pin_out}, {core_oe, core_out});
  endtask : t_preload

  task automatic t_array;
    ctrl.scan(1'b1, IR_ARM, 4, d);
    repeat (10) @(negedge clk);
    check({pin_oe, pin_out}, {8'hff, PRE});
    core_out = 8'hc6;
    ctrl.scan(1'b1, IR_ERASE, 4, d);
    op_done;
    check({pin_oe, pin_out}, {8'hff, PRE});
    ctrl.scan(1'b1, IR_PROGRAM, 4, d);
    op_done;
    ctrl.scan(1'b0, {3'd5, 16'hc3a5}, 19, d);
    op_done;
    ctrl.scan(1'b1, IR_VERIFY, 4, d);
    op_done;
    ctrl.scan(1'b0, {3'd3, 16'h0000}, 19, d);
    op_done;
    ctrl.scan(1'b0, {3'd5, 16'h0000}, 19, d);
    check(d[18:0], {3'd3, 16'hffff});
    op_done;
    ctrl.scan(1'b0, 19'h0, 19, d);
    check(d[18:0], {3'd5, 16'hc3a5});
    op_done;
    // Row 0 took a zero word from the empty register; erase must restore it
    ctrl.scan(1'b1, IR_ERASE, 4, d);
    op_done;
    ctrl.scan(1'b1, IR_VERIFY, 4, d);
    op_done;
    ctrl.scan(1'b0, 19'h0, 19, d);
    check(d[18:0], {3'd0, 16'hffff});
    op_done;
  endtask : t_array

  task automatic t_disarm;
    ctrl.tlr;
    ctrl.scan(1'b1, IR_VERIFY, 4, d);
    no_op;
    check({pin_oe, pin_out}, {core_oe, core_out});
  endtask : t_disarm

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    pin_in = 8'ha3;
    core_out = 8'h3c;
    core_oe = 8'h0f;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(negedge clk);
    check({busy, tdo_oe, pin_oe, pin_out}, 18'h0);
    rst_n = 1'b1;
    ctrl.tlr;
    t_unarmed;
    t_preload;
    t_array;
    t_disarm;
    final_report;
  end
endmodule : tb_jrp_top
